// ### src/twi_irq_defs.svh
// register offsets, field positions, reset values and timing figures of the
// two-wire controller slice; included by the design file, the checker and the bench top
`ifndef TWI_IRQ_DEFS_SVH
`define TWI_IRQ_DEFS_SVH
// byte offsets on the register bus
`define OFS_SLAVE_ADDR 5'h00
`define OFS_RATE_DIV 5'h04
`define OFS_CONTROL 5'h08
`define OFS_STATUS 5'h0C
`define OFS_DATA 5'h10
`define OFS_ADDR_CFG 5'h14
// control register fields
`define CTL_EN 7
`define CTL_IE 6
`define CTL_MST 5
`define CTL_TX 4
`define CTL_ACK_DISABLE_BIT 3
`define CTL_REPEATED_START_REQUEST 2
// status register fields
`define STS_TCF 7
`define STS_ADDRESSED_AS_SLAVE_FLAG 6
`define STS_BUSY 5
`define STS_ARBITRATION_LOST_FLAG 4
`define STS_SRW 2
`define STS_IIF 1
`define STS_RECEIVED_ACK_BIT 0
// address configuration fields
`define CFG_GCEN 7
`define CFG_EXT 6
// reset values
`define RST_BYTE 8'h00
`define RST_TCF 1'b1
// ten-bit first byte prefix and general call address
`define TEN_BIT_PREFIX 5'h1E
`define GEN_CALL_ADDR 8'h00
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// clock period in ns, for reference by timing figures
`define CLK_PERIOD_NS 10
`endif

// ### src/twi_irq_pkg.sv
// types shared by the two-wire controller slice and its bench
// assumes the defs header sits on the include path
package twi_irq_pkg;
  // register bus requests from the master
  typedef struct packed
  {
    logic awvalid;
    logic [4:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [4:0] araddr;
    logic rready;
  } axil_req_t;
  // register bus answers from the slave
  typedef struct packed
  {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;
  // byte transfer phase of the received stream
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b001,
    PH_FIRST = 3'b010,
    PH_NEXT = 3'b100
  } phase_t;
endpackage

// ### src/twi_irq_ctrl.sv
// two-wire controller: interrupt, status flags and register model
// assumes the bit engine sits beside it on clock_i, and scl/sda pins arrive
// unsynchronised from the open-drain bus
//
// Operation
// - one interrupt output shared by every event source
// - interrupt output is flag AND enable; flag sets even when disabled
// - interrupt flag clears only on a software write of one
// - byte done, address match and arbitration loss each set the flag
// - transfer complete sets at the falling edge of the ninth clock
// - address match sets on own address or enabled general call
// - master loses arbitration seeing sda low while driving high when transmitting
// - master loses arbitration seeing sda low while driving ack high receiving
// - start attempted while bus busy loses arbitration
// - repeated start requested in slave mode loses arbitration
// - stop not requested by the master loses arbitration
// - arbitration lost stays set until software writes one to it
// - bit rate is bus clock over two times multiplier times divider
// - slave answers the seven-bit address in bits seven to one
// - ten-bit mode interrupts after first address byte; data then invalid
// - address config holds general call, ten-bit, zero, upper address bits
// - module is disabled after reset and never resets the system
// - general call is not acknowledged when disabled, but its bytes still load the data register
// - ten-bit first byte recognised by prefix 11110, upper bits, direction
`timescale 1ns/1ps
`include "twi_irq_defs.svh"
module twi_irq_ctrl
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // register bus
  input wire twi_irq_pkg::axil_req_t axi_i,
  output twi_irq_pkg::axil_rsp_t axi_o,
  // bus lines as seen on the pins
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  // from the bit engine
  input wire logic eng_sda_high_i,
  input wire logic eng_tx_bit_i,
  input wire logic eng_rx_ack_i,
  input wire logic eng_stop_req_i,
  // to the bit engine
  output logic [7:0] tx_byte_o,
  output logic tx_load_o,
  output logic [7:0] control_o,
  output logic ack_addr_o,
  output logic rate_tick_o,
  // interrupt
  output logic irq_o
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  // second stage only feeds logic; first stage read by nothing else
  always_ff @(posedge clock_i)
  begin
    scl_sync_r <= {scl_sync_r[0], scl_pin_i};
    sda_sync_r <= {sda_sync_r[0], sda_pin_i};
    scl_prev_r <= scl_sync_r[1];
    sda_prev_r <= sda_sync_r[1];
  end
  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];
  wire scl_rise = scl_s & ~scl_prev_r;
  wire scl_fall = ~scl_s & scl_prev_r;
  wire start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  wire stop_det = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

  // ==========================================================
  // registers
  logic [7:0] sar_r;
  logic [7:0] rate_r;
  logic [7:0] ctl_r;
  logic [7:0] cfg_r;
  logic [7:0] rx_r;
  logic tcf_r;
  logic addressed_as_slave_flag_r;
  logic busy_r;
  logic arbitration_lost_flag_r;
  logic srw_r;
  logic iif_r;
  logic received_ack_bit_r;
  logic ten_first_r;

  // ==========================================================
  // register bus slave
  logic aw_held_r;
  logic w_held_r;
  logic [4:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // address and data may arrive in either order; the write happens once both are in
  wire aw_take = axi_i.awvalid & ~aw_held_r;
  wire w_take = axi_i.wvalid & ~w_held_r;
  wire do_wr = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_en = do_wr & wstrb0_r;
  wire do_rd = axi_i.arvalid & ~rvalid_r;
  wire wr_sar = wr_en & (awaddr_r == `OFS_SLAVE_ADDR);
  wire wr_rate = wr_en & (awaddr_r == `OFS_RATE_DIV);
  wire wr_ctl = wr_en & (awaddr_r == `OFS_CONTROL);
  wire wr_sts = wr_en & (awaddr_r == `OFS_STATUS);
  wire wr_dat = wr_en & (awaddr_r == `OFS_DATA);
  wire wr_cfg = wr_en & (awaddr_r == `OFS_ADDR_CFG);
  wire rd_dat = do_rd & (axi_i.araddr == `OFS_DATA);
  wire wr_hit = (awaddr_r == `OFS_SLAVE_ADDR) | (awaddr_r == `OFS_RATE_DIV)
    | (awaddr_r == `OFS_CONTROL) | (awaddr_r == `OFS_STATUS)
    | (awaddr_r == `OFS_DATA) | (awaddr_r == `OFS_ADDR_CFG);
  // status word, reserved bit reads zero
  wire [7:0] sts_word = {tcf_r, addressed_as_slave_flag_r, busy_r, arbitration_lost_flag_r, 1'b0, srw_r, iif_r, received_ack_bit_r};
  logic [7:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (axi_i.araddr)
      `OFS_SLAVE_ADDR: rd_mux = sar_r;
      `OFS_RATE_DIV: rd_mux = rate_r;
      `OFS_CONTROL: rd_mux = ctl_r;
      `OFS_STATUS: rd_mux = sts_word;
      `OFS_DATA: rd_mux = rx_r;
      `OFS_ADDR_CFG: rd_mux = {cfg_r[7:6], 1'b0, 2'b00, cfg_r[2:0]};
      default:
      begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  // bus handshake state
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= axi_i.awaddr;
      end
      if (w_take)
      begin
        w_held_r <= 1'b1;
        wdata_r <= axi_i.wdata[7:0];
        wstrb0_r <= axi_i.wstrb[0];
      end
      if (do_wr)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_r & axi_i.bready)
      begin
        bvalid_r <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (do_rd)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, rd_mux};
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_r & axi_i.rready)
        rvalid_r <= 1'b0;
    end
  end
  assign axi_o.awready = ~aw_held_r;
  assign axi_o.wready = ~w_held_r;
  assign axi_o.bvalid = bvalid_r;
  assign axi_o.bresp = bresp_r;
  assign axi_o.arready = ~rvalid_r;
  assign axi_o.rvalid = rvalid_r;
  assign axi_o.rdata = rdata_r;
  assign axi_o.rresp = rresp_r;

  // ==========================================================
  // receive stream: bit count, shifter, phase
  twi_irq_pkg::phase_t phase_r;
  logic [3:0] bits_r;
  logic [7:0] shift_r;
  logic ten_hit_r;
  wire en = ctl_r[`CTL_EN];
  // ninth falling clock edge closes a byte
  wire byte_done = en & (phase_r != twi_irq_pkg::PH_IDLE) & scl_fall & (bits_r == 4'd9);
  always_ff @(posedge clock_i)
  begin
    if (srst_i | ~en | stop_det)
    begin
      phase_r <= twi_irq_pkg::PH_IDLE;
      bits_r <= 4'd0;
      shift_r <= 8'h00;
    end
    else if (start_det)
    begin
      phase_r <= twi_irq_pkg::PH_FIRST;
      bits_r <= 4'd0;
    end
    else
    begin
      if (scl_rise & (bits_r < 4'd8))
        shift_r <= {shift_r[6:0], sda_s};
      if (scl_rise & (phase_r != twi_irq_pkg::PH_IDLE))
        bits_r <= bits_r + 4'd1;
      if (byte_done)
      begin
        bits_r <= 4'd0;
        phase_r <= twi_irq_pkg::PH_NEXT;
      end
    end
  end

  // ==========================================================
  // address recognition
  wire first = (phase_r == twi_irq_pkg::PH_FIRST);
  wire ext = cfg_r[`CFG_EXT];
  wire gc_hit = cfg_r[`CFG_GCEN] & (shift_r == `GEN_CALL_ADDR);
  wire own7 = ~ext & (shift_r[7:1] == sar_r[7:1]);
  wire ten_pre = ext & (shift_r[7:3] == `TEN_BIT_PREFIX)
    & (shift_r[2:1] == cfg_r[2:1]);
  wire ten_second = ext & ten_first_r & (phase_r == twi_irq_pkg::PH_NEXT) & ~addressed_as_slave_flag_r
    & (shift_r == {cfg_r[0], sar_r[7:1]});
  wire ten_read = ten_pre & shift_r[0] & ten_hit_r;
  wire slave_ok = ~ctl_r[`CTL_MST];
  wire addr_match = byte_done & slave_ok
    & ((first & (own7 | gc_hit | ten_read)) | ten_second);
  // first ten-bit byte raises the flag alone; the received data is not valid then
  wire ten_first_ev = byte_done & slave_ok & first & ten_pre & ~shift_r[0];
  // acknowledge hint to the engine after the eighth address bit
  assign ack_addr_o = en & slave_ok & (bits_r == 4'd8)
    & ((first & (own7 | gc_hit | ten_pre)) | ten_second);

  // ==========================================================
  // arbitration checks
  wire drive_high = ctl_r[`CTL_MST] & eng_sda_high_i;
  wire lost_tx = scl_rise & drive_high & eng_tx_bit_i & ~sda_s;
  wire lost_ack = scl_rise & drive_high & eng_rx_ack_i & ~sda_s;
  wire lost_start = wr_ctl & wdata_r[`CTL_MST] & ~ctl_r[`CTL_MST] & busy_r;
  wire lost_repeated_start_request = wr_ctl & wdata_r[`CTL_REPEATED_START_REQUEST] & ~ctl_r[`CTL_MST];
  wire lost_stop = stop_det & ctl_r[`CTL_MST] & ~eng_stop_req_i;
  wire arb_lost = en & (lost_tx | lost_ack | lost_start | lost_repeated_start_request | lost_stop);

  // ==========================================================
  // configuration registers; disabled out of reset
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      sar_r <= `RST_BYTE;
      rate_r <= `RST_BYTE;
      cfg_r <= `RST_BYTE;
      ctl_r <= `RST_BYTE;
    end
    else
    begin
      if (wr_sar)
        sar_r <= {wdata_r[7:1], 1'b0};
      if (wr_rate)
        rate_r <= wdata_r;
      if (wr_cfg)
        cfg_r <= {wdata_r[7:6], 3'b000, wdata_r[2:0]};
      // loser drops to slave without a stop; restart request is a one-shot
      if (arb_lost)
        ctl_r <= {ctl_r[7:6], 1'b0, (wr_ctl ? wdata_r[4:3] : ctl_r[4:3]), 3'b000};
      else if (wr_ctl)
        ctl_r <= {wdata_r[7:2], 2'b00};
      else if (ctl_r[`CTL_REPEATED_START_REQUEST])
        ctl_r[`CTL_REPEATED_START_REQUEST] <= 1'b0;
    end
  end
  assign control_o = ctl_r;

  // ==========================================================
  // status flags; a hardware set wins over a software clear
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      tcf_r <= `RST_TCF;
      addressed_as_slave_flag_r <= 1'b0;
      busy_r <= 1'b0;
      arbitration_lost_flag_r <= 1'b0;
      srw_r <= 1'b0;
      iif_r <= 1'b0;
      received_ack_bit_r <= 1'b0;
      rx_r <= `RST_BYTE;
      ten_first_r <= 1'b0;
      ten_hit_r <= 1'b0;
    end
    else
    begin
      if (start_det)
        busy_r <= 1'b1;
      else if (stop_det)
        busy_r <= 1'b0;
      if (byte_done)
        tcf_r <= 1'b1;
      else if (wr_dat | rd_dat | (en & scl_fall & (bits_r == 4'd0)))
        tcf_r <= 1'b0;
      if (addr_match)
      begin
        addressed_as_slave_flag_r <= 1'b1;
        srw_r <= first & shift_r[0];
      end
      else if (stop_det | wr_ctl)
        addressed_as_slave_flag_r <= 1'b0;
      if (ten_first_ev)
        ten_first_r <= 1'b1;
      else if (stop_det)
        ten_first_r <= 1'b0;
      if (addr_match & ext)
        ten_hit_r <= 1'b1;
      else if (stop_det)
        ten_hit_r <= 1'b0;
      if (arb_lost)
        arbitration_lost_flag_r <= 1'b1;
      else if (wr_sts & wdata_r[`STS_ARBITRATION_LOST_FLAG])
        arbitration_lost_flag_r <= 1'b0;
      if (byte_done | addr_match | ten_first_ev | arb_lost)
        iif_r <= 1'b1;
      else if (wr_sts & wdata_r[`STS_IIF])
        iif_r <= 1'b0;
      if (en & scl_rise & (bits_r == 4'd8))
        received_ack_bit_r <= sda_s;
      if (byte_done & ~ctl_r[`CTL_TX])
        rx_r <= shift_r;
    end
  end
  assign irq_o = iif_r & ctl_r[`CTL_IE];

  // ==========================================================
  // transmit load: a data write in transmit mode hands the byte to the engine
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      tx_byte_o <= `RST_BYTE;
      tx_load_o <= 1'b0;
    end
    else
    begin
      tx_load_o <= wr_dat & en & ctl_r[`CTL_TX];
      if (wr_dat)
        tx_byte_o <= wdata_r;
    end
  end

  // ==========================================================
  // bit rate: one tick per half bit, so a bit spans 2 * rate_multiplier * div clocks
  logic [13:0] rate_cnt_r;
  logic [2:0] rate_multiplier;
  always_comb
  begin
    unique case (rate_r[7:6])
      2'b01: rate_multiplier = 3'd2;
      2'b10: rate_multiplier = 3'd4;
      default: rate_multiplier = 3'd1;
    endcase
  end
  // divider is the low field plus one, so no setting stalls the clock
  wire [13:0] half_bit = 14'({8'h00, rate_r[5:0]} + 14'd1) * 14'(rate_multiplier);
  always_ff @(posedge clock_i)
  begin
    if (srst_i | ~en)
    begin
      rate_cnt_r <= 14'd0;
      rate_tick_o <= 1'b0;
    end
    else if (rate_cnt_r >= half_bit - 14'd1)
    begin
      rate_cnt_r <= 14'd0;
      rate_tick_o <= 1'b1;
    end
    else
    begin
      rate_cnt_r <= rate_cnt_r + 14'd1;
      rate_tick_o <= 1'b0;
    end
  end
endmodule

// ### testbench/twi_irq_ctrl_properties.sv
// checker: bus answers, interrupt gating and control pulses of twi_irq_ctrl
// assumes it sees only the top ports and is bound into every instance
`timescale 1ns/1ps
`include "twi_irq_defs.svh"
module twi_irq_ctrl_properties
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // register bus
  input wire twi_irq_pkg::axil_req_t axi_i,
  input wire twi_irq_pkg::axil_rsp_t axi_o,
  // outputs to the engine and the interrupt
  input wire logic tx_load_o,
  input wire logic [7:0] control_o,
  input wire logic rate_tick_o,
  input wire logic irq_o
);
  // ==========
  // handshake steps
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence s_wr_both;
    axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready;
  endsequence
  sequence s_rd_take;
    axi_i.arvalid && axi_o.arready;
  endsequence
  sequence s_rd_bad;
    s_rd_take ##0 (axi_i.araddr > 5'h17);
  endsequence
  // ==========
  // properties; one cycle of slack on irq, though control_o is a same-cycle copy of the control register
  a_irq_masked: assert property (irq_o |-> ##[0:1] control_o[`CTL_IE])
    else $error("irq high with its enable clear");
  a_reset_idle: assert property ($fell(srst_i) |-> !irq_o && control_o == 8'h00)
    else $error("module not idle after reset");
  a_load_gated: assert property (tx_load_o |-> control_o[`CTL_EN] && control_o[`CTL_TX])
    else $error("byte load outside enabled transmit");
  a_load_pulse: assert property (tx_load_o |=> !tx_load_o)
    else $error("byte load longer than one cycle");
  a_tick_gated: assert property (rate_tick_o |-> $past(control_o[`CTL_EN]))
    else $error("rate tick while disabled");
  a_restart_self: assert property (control_o[`CTL_REPEATED_START_REQUEST] |=> !control_o[`CTL_REPEATED_START_REQUEST])
    else $error("restart request did not clear");
  a_write_answer: assert property (s_wr_both |=> ##1 axi_o.bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_rd_take |=> axi_o.rvalid && axi_o.rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  a_write_refuse: assert property (axi_o.bvalid |-> !axi_o.awready && !axi_o.wready)
    else $error("write taken while answer pending");
  a_read_refuse: assert property (axi_o.rvalid |-> !axi_o.arready)
    else $error("read taken while answer pending");
  a_unmapped_read: assert property (s_rd_bad |=> axi_o.rresp == `RESP_SLVERR && axi_o.rdata == 0)
    else $error("unmapped read not refused");
endmodule
bind twi_irq_ctrl twi_irq_ctrl_properties chk
(
  .clock_i(clock_i), .srst_i(srst_i), .axi_i(axi_i), .axi_o(axi_o), .tx_load_o(tx_load_o),
  .control_o(control_o), .rate_tick_o(rate_tick_o), .irq_o(irq_o)
);

// ### testbench/twi_bus_partner.sv
// bus partner: another master on the open-drain two-wire lines
// assumes the bench turns its pulls into line levels with pull-ups
`timescale 1ns/1ps
module twi_bus_partner
#(
  parameter int HALF = 8
)
(
  // clock
  input wire logic clock_i,
  // pulls, high while the line is held low
  output logic scl_low_o,
  output logic sda_low_o
);
  // ==========
  // line sequencing
  // released at start so the pull-ups hold the bus idle; clock stands still
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // a third of a bit, well above the two-cycle pin sampling delay
  task gap;
    repeat (HALF) @(posedge clock_i);
  endtask
  // also serves as repeated start from the clock-low state
  task start_c;
    sda_low_o <= 1'b0;
    gap;
    scl_low_o <= 1'b0;
    gap;
    sda_low_o <= 1'b1;
    gap;
    scl_low_o <= 1'b1;
    gap;
  endtask
  // data changes only while the clock is low; a pulled zero wins the bus
  task bit_c(input logic bv);
    sda_low_o <= !bv;
    gap;
    scl_low_o <= 1'b0;
    gap;
    scl_low_o <= 1'b1;
    gap;
  endtask
  // msb first, then the acknowledge slot as the ninth clock
  task byte_c(input logic [7:0] bt, input logic ack);
    for (int i = 7; i >= 0; i--)
      bit_c(bt[i]);
    bit_c(ack);
  endtask
  task stop_c;
    sda_low_o <= 1'b1;
    gap;
    scl_low_o <= 1'b0;
    gap;
    sda_low_o <= 1'b0;
    gap;
  endtask
endmodule

// ### testbench/twi_irq_ctrl_tb_top.sv
// bench: register model, addressing, arbitration and bit rate checks
// assumes the partner model and the bound checker are compiled before it
`timescale 1ns/1ps
`include "twi_irq_defs.svh"
module twi_irq_ctrl_tb_top;
  // ==========
  // signals and model state
  localparam logic [7:0] MASK [0:5] = '{8'hFE, 8'hFF, 8'hF8, 8'h00, 8'h00, 8'hC7};
  logic clock_i, srst_i, eng_high, eng_tx, eng_ack, eng_stop, tx_load, tick, irq;
  twi_irq_pkg::axil_req_t req;
  twi_irq_pkg::axil_rsp_t rsp;
  logic [7:0] tx_byte, ctl, v, a, d, b;
  logic [2:0] hi;
  logic [31:0] seed;
  wire scl_low, sda_low;
  int fails, comparisons, cyc, loads, k, n;
  // the block drives no pins, so each line is pull-up and the partner's pull
  twi_bus_partner bus (.clock_i(clock_i), .scl_low_o(scl_low), .sda_low_o(sda_low));
  twi_irq_ctrl DUT
  (
    .clock_i(clock_i), .srst_i(srst_i), .axi_i(req), .axi_o(rsp),
    .scl_pin_i(!scl_low), .sda_pin_i(!sda_low), .eng_sda_high_i(eng_high),
    .eng_tx_bit_i(eng_tx), .eng_rx_ack_i(eng_ack), .eng_stop_req_i(eng_stop),
    .tx_byte_o(tx_byte), .tx_load_o(tx_load), .control_o(ctl), .ack_addr_o(),
    .rate_tick_o(tick), .irq_o(irq)
  );
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // cycle ceiling and count of byte loads
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (tx_load === 1'b1)
      loads <= loads + 1;
    if (cyc == 60000)
    begin
      fails++;
      close_out;
    end
  end
  // ==========
  // tasks
  task close_out;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // write: address and data offered together, each dropped once taken
  task wr(input logic [4:0] ad, input logic [7:0] dt, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock_i);
    req.awvalid <= 1'b1;
    req.awaddr <= ad;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, dt};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clock_i);
      aw_done = aw_done | (rsp.awready === 1'b1);
      w_done = w_done | (rsp.wready === 1'b1);
      if (aw_done)
        req.awvalid <= 1'b0;
      if (w_done)
        req.wvalid <= 1'b0;
    end
    do @(posedge clock_i); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check(rsp.bresp, er);
  endtask
  task rd(input logic [4:0] ad, input logic [1:0] er, output logic [7:0] dt);
    @(posedge clock_i);
    req.arvalid <= 1'b1;
    req.araddr <= ad;
    req.rready <= 1'b1;
    do @(posedge clock_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clock_i); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    dt = rsp.rdata[7:0];
    check({rsp.rdata[31:8], rsp.rresp}, {24'h0, er});
  endtask
  // ==========
  // main sequence
  initial
  begin
    req = '0;
    srst_i = 1'b1;
    {eng_high, eng_tx, eng_ack, eng_stop} = 4'h0;
    seed = 32'h00003E8D;
    {fails, comparisons, cyc, loads} = '0;
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    // reset values; data read last of the first five clears transfer complete
    for (k = 0; k < 6; k++)
    begin
      rd(5'(k * 4), `RESP_OKAY, v);
      check(v, (k == 3) ? 8'h80 : 8'h00);
    end
    rd(5'h18, `RESP_SLVERR, v);
    check(v, 8'h00);
    wr(5'h1C, 8'hFF, `RESP_SLVERR);
    // random read-back of address, rate and configuration
    for (k = 0; k < 9; k++)
    begin
      n = (k % 3 == 2) ? 5 : k % 3;
      d = 8'(xs());
      wr(5'(n * 4), d, `RESP_OKAY);
      rd(5'(n * 4), `RESP_OKAY, v);
      check(v, d & MASK[n]);
    end
    wr(`OFS_CONTROL, 8'hD8, `RESP_OKAY);
    rd(`OFS_CONTROL, `RESP_OKAY, v);
    check({v, ctl}, 16'hD8D8);
    // a data write loads the shifter only in transmit mode
    n = loads;
    wr(`OFS_DATA, 8'h5A, `RESP_OKAY);
    wr(`OFS_CONTROL, 8'h80, `RESP_OKAY);
    wr(`OFS_DATA, 8'hA5, `RESP_OKAY);
    check({tx_byte, 8'(loads - n)}, 16'hA501);
    // own address, foreign address, general call refused and accepted
    a = {1'b0, 7'(xs())} | 8'h01;
    wr(`OFS_ADDR_CFG, 8'h00, `RESP_OKAY);
    wr(`OFS_SLAVE_ADDR, {a[6:0], 1'b0}, `RESP_OKAY);
    for (k = 0; k < 4; k++)
    begin
      b = (k == 0) ? {a[6:0], 1'b0} : (k == 1) ? {a[6:0] ^ 7'h02, 1'b0} : 8'h00;
      wr(`OFS_ADDR_CFG, (k == 3) ? 8'h80 : 8'h00, `RESP_OKAY);
      wr(`OFS_CONTROL, (k == 1) ? 8'h80 : 8'hC0, `RESP_OKAY);
      wr(`OFS_STATUS, 8'h12, `RESP_OKAY);
      bus.start_c();
      bus.byte_c(b, 1'b1);
      rd(`OFS_STATUS, `RESP_OKAY, v);
      check(v & 8'hFE, 8'hA2 | ((k % 3 == 0) ? 8'h40 : 8'h00));
      check(irq, k != 1);
      wr(`OFS_STATUS, 8'h02, `RESP_OKAY);
      rd(`OFS_STATUS, `RESP_OKAY, v);
      check({v[1], irq}, 2'b00);
      if (k % 3 == 0)
      begin
        d = 8'(xs());
        bus.byte_c(d, 1'b1);
        rd(`OFS_DATA, `RESP_OKAY, v);
        check(v, d);
      end
      bus.stop_c();
      rd(`OFS_STATUS, `RESP_OKAY, v);
      check(v[6:5], 2'b00);
    end
    // ten-bit: first byte interrupts without addressing, second addresses
    hi = 3'(xs());
    wr(`OFS_ADDR_CFG, {5'h08, hi}, `RESP_OKAY);
    wr(`OFS_STATUS, 8'h12, `RESP_OKAY);
    bus.start_c();
    bus.byte_c({`TEN_BIT_PREFIX, hi[2:1], 1'b0}, 1'b1);
    rd(`OFS_STATUS, `RESP_OKAY, v);
    check(v & 8'hC2, 8'h82);
    wr(`OFS_STATUS, 8'h02, `RESP_OKAY);
    bus.byte_c({hi[0], a[6:0]}, 1'b1);
    rd(`OFS_STATUS, `RESP_OKAY, v);
    check(v & 8'hC2, 8'hC2);
    bus.stop_c();
    // losses: transmit bit, receive ack, busy start, slave restart, stray stop;
    // last case is a requested stop, which must not lose
    for (k = 0; k < 6; k++)
    begin
      eng_tx <= (k == 0);
      eng_ack <= (k == 1);
      eng_stop <= (k == 5);
      eng_high <= 1'b1;
      wr(`OFS_CONTROL, (k == 3) ? 8'h84 : (k == 2) ? 8'h80 : 8'hB0, `RESP_OKAY);
      if (k != 3)
        bus.start_c();
      if (k < 2)
        bus.byte_c(k ? 8'hFF : 8'h00, k == 0);
      if (k == 2)
        wr(`OFS_CONTROL, 8'hA0, `RESP_OKAY);
      if (k > 3)
        bus.stop_c();
      rd(`OFS_STATUS, `RESP_OKAY, v);
      check({v[4], v[1]}, (k == 5) ? 2'b00 : 2'b11);
      rd(`OFS_CONTROL, `RESP_OKAY, v);
      check(v[5], k == 5);
      if (k < 3)
        bus.stop_c();
      wr(`OFS_STATUS, 8'hEF, `RESP_OKAY);
      rd(`OFS_STATUS, `RESP_OKAY, v);
      check(v[4], k != 5);
      wr(`OFS_STATUS, 8'h10, `RESP_OKAY);
      rd(`OFS_STATUS, `RESP_OKAY, v);
      check({v[4], v[1]}, 2'b00);
    end
    {eng_high, eng_tx, eng_ack, eng_stop} <= 4'h0;
    // bit rate for every multiplier code; two ticks skipped to settle
    for (k = 0; k < 4; k++)
    begin
      d = {k[1:0], 3'b000, 3'(xs())};
      wr(`OFS_RATE_DIV, d, `RESP_OKAY);
      wr(`OFS_CONTROL, 8'h80, `RESP_OKAY);
      repeat (2) do @(posedge clock_i); while (tick !== 1'b1);
      n = 0;
      do
      begin
        @(posedge clock_i);
        n++;
      end
      while (tick !== 1'b1);
      check(n, (d[2:0] + 1) * ((k == 2) ? 4 : (k == 1) ? 2 : 1));
    end
    close_out;
  end
endmodule
